// ---- rmr_pkg.sv ----
// constants, field layout and types for the relay matrix route block
// assumes a single pclk domain and an APB register port
package rmr_pkg;
	localparam int NCARD = 4;
	localparam int NIN = 10;
	localparam int NOUT = 12;
	localparam int NREL = NIN * NOUT;
	localparam int CLK_NS = 4;
	localparam int RELAY_SETTLE_NS = 20;
	localparam int SETTLE_CYC = (RELAY_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_RESP = 8'h08;
	localparam int F_OP = 0;
	localparam int F_CARD = 4;
	localparam int F_ARG = 8;
	localparam int F_OUT = 12;
	localparam int F_BUSY = 0;
	localparam int F_ERR = 1;
	localparam int F_AUTO = 2;
	localparam int F_RVALID = 16;
	localparam logic [2:0] CARD_ALL = 3'h7;
	localparam logic [7:0] NEWLINE = 8'h0A;
	localparam logic [3:0] RST_BIAS_PORT = 4'hA;
	localparam logic [NOUT-1:0] RST_BIAS_EN = 12'hFFF;
	localparam logic [4:0] RST_COUP = 5'h00;
	localparam logic [2:0] SETTLE_LD = 3'(SETTLE_CYC);
	typedef enum logic [1:0] {
		no_sequence_mode = 2'b00,
		break_first_mode = 2'b01,
		make_first_mode = 2'b10
	} rmr_seq_type;
	localparam rmr_seq_type break_first_default = break_first_mode;
	typedef enum logic [0:0] {
		normal_channel_config = 1'b0,
		auto_channel_config = 1'b1
	} rmr_cfg_type;
	typedef enum logic [3:0] {
		op_nop = 4'h0, op_seq_set = 4'h1, op_seq_qry = 4'h2, op_rule_set = 4'h3,
		op_coup_port_set = 4'h4, op_coup_port_qry = 4'h5, op_coup_en_set = 4'h6,
		op_coup_en_qry = 4'h7, op_func_set = 4'h8, op_func_qry = 4'h9,
		op_open_card = 4'hA, op_open_chan = 4'hB, op_close_chan = 4'hC,
		op_bias_set = 4'hD, op_dev_reset = 4'hE, op_card_pon = 4'hF
	} rmr_op_type;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_exec = 2'b01,
		st_seq = 2'b10
	} rmr_state_type;
endpackage

// ---- rmr_ifs.sv ----
// carriers between the route block and its sequencer and channel mapper
// assumes all members live in the pclk domain
`timescale 1ns/10ps
interface rmr_seq_if;
	import rmr_pkg::*;
	logic start;
	rmr_seq_type mode;
	logic open_p;
	logic close_p;
	logic done;
	logic busy;
	modport ctl (output start, output mode, input open_p, input close_p, input done, input busy);
	modport eng (input start, input mode, output open_p, output close_p, output done, output busy);
endinterface

interface rmr_map_if;
	logic [3:0] in_num;
	logic [3:0] out_num;
	logic [4:0] cp_mask;
	logic cp_on;
	logic [3:0] in0;
	logic [3:0] oc0;
	logic [6:0] idx0;
	logic [6:0] idx1;
	logic pair;
	logic valid;
	modport user (output in_num, output out_num, output cp_mask, output cp_on,
		input in0, input oc0, input idx0, input idx1, input pair, input valid);
	modport map (input in_num, input out_num, input cp_mask, input cp_on,
		output in0, output oc0, output idx0, output idx1, output pair, output valid);
endinterface

// ---- rmr_seq.sv ----
// relay open/close ordering engine with a settle gap
// assumes start is a one-cycle pulse while the engine is idle
`timescale 1ns/10ps
module rmr_seq
	import rmr_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// control
	rmr_seq_if.eng sq
);
	logic wait_r;
	logic [2:0] cnt_r;
	rmr_seq_type mode_r;

	assign sq.busy = wait_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_r <= 1'b0;
			cnt_r <= 3'h0;
			mode_r <= no_sequence_mode;
			sq.open_p <= 1'b0;
			sq.close_p <= 1'b0;
			sq.done <= 1'b0;
		end
		else if (pce)
		begin
			sq.open_p <= 1'b0;
			sq.close_p <= 1'b0;
			sq.done <= 1'b0;
			if (!wait_r && sq.start)
			begin
				mode_r <= sq.mode;
				case (sq.mode)
					break_first_mode:
					begin
						sq.open_p <= 1'b1;
						wait_r <= 1'b1;
						cnt_r <= SETTLE_LD;
					end
					make_first_mode:
					begin
						sq.close_p <= 1'b1;
						wait_r <= 1'b1;
						cnt_r <= SETTLE_LD;
					end
					default:
					begin
						sq.open_p <= 1'b1;
						sq.close_p <= 1'b1;
						sq.done <= 1'b1;
					end
				endcase
			end
			else if (wait_r)
			begin
				cnt_r <= cnt_r - 3'h1;
				if (cnt_r == 3'h1)
				begin
					wait_r <= 1'b0;
					sq.done <= 1'b1;
					sq.open_p <= (mode_r == make_first_mode);
					sq.close_p <= (mode_r == break_first_mode);
				end
			end
		end
	end

	a_break_order: assert property (@(posedge pclk) disable iff (!presetn)
		pce && sq.start && !wait_r && sq.mode == break_first_mode
		|=> sq.open_p && !sq.close_p ##5 sq.close_p)
		else $error("break-first order wrong");
	a_make_order: assert property (@(posedge pclk) disable iff (!presetn)
		pce && sq.start && !wait_r && sq.mode == make_first_mode
		|=> sq.close_p && !sq.open_p ##5 sq.open_p)
		else $error("make-first order wrong");
	c_make_seq: cover property (@(posedge pclk) disable iff (!presetn)
		sq.start && sq.mode == make_first_mode);
endmodule

// ---- rmr_chan_map.sv ----
// maps a channel request onto one or two relay indices, coupling aware
// assumes 1-based port numbers from the command word
`timescale 1ns/10ps
module rmr_chan_map
	import rmr_pkg::*;
(
	// channel request
	rmr_map_if.map mi
);
	logic in_ok;
	logic out_ok;
	logic [3:0] o0;

	always_comb
	begin
		in_ok = (mi.in_num >= 4'h1) && (mi.in_num <= 4'(NIN));
		out_ok = (mi.out_num >= 4'h1) && (mi.out_num <= 4'(NOUT));
		mi.valid = in_ok && out_ok;
		mi.in0 = mi.in_num - 4'h1;
		// odd input pairs with next input
		mi.pair = mi.cp_on && in_ok && mi.in_num[0] && (mi.in_num <= 4'h9)
			&& mi.cp_mask[mi.in_num[3:1]];
		o0 = mi.out_num - 4'h1;
		// even output folds to odd below
		mi.oc0 = mi.pair ? {o0[3:1], 1'b0} : o0;
		mi.idx0 = 7'(int'(mi.in0) * NOUT + int'(mi.oc0));
		mi.idx1 = mi.idx0 + 7'(NOUT + 1);
	end
endmodule

// ---- rmr_route_cfg.sv ----
// per-card route configuration and opening logic of a relay matrix
// assumes an APB master on pclk and card type levels synchronous to pclk
`timescale 1ns/10ps
module rmr_route_cfg
	import rmr_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cards
	input wire logic [NCARD-1:0] card_is_mux,
	output logic [NCARD-1:0][NREL-1:0] relay_state
);
	rmr_seq_if sq ();
	rmr_map_if mi ();

	rmr_state_type state_r;
	logic [15:0] cmd_r;
	logic err_r;
	logic [16:0] resp_r;
	rmr_cfg_type cfg_r;
	rmr_seq_type seq_r [NCARD];
	logic rule_r [NCARD];
	logic [4:0] cp_r [NCARD];
	logic cpen_r [NCARD];
	logic bias_r [NCARD];
	logic [3:0] bp_r [NCARD];
	logic [NOUT-1:0] ben_r [NCARD];
	logic [NREL-1:0] relay_r [NCARD];
	logic [NCARD-1:0] cpl_hit;
	logic [NCARD-1:0] bias_hit;

	rmr_op_type op;
	logic [2:0] card;
	logic [7:0] arg;
	logic set_ok;
	logic qry_ok;
	logic [1:0] qc;
	logic [NCARD-1:0] sel;
	logic bad;
	logic exec;
	logic pon_all;
	logic busy;
	logic apb_acc;
	logic cmd_go;
	logic [7:0] qval;

	rmr_seq u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.sq(sq.eng)
	);

	rmr_chan_map u_map (
		.mi(mi.map)
	);

	always_comb
	begin
		op = rmr_op_type'(cmd_r[F_OP+:4]);
		card = cmd_r[F_CARD+:3];
		arg = cmd_r[F_ARG+:8];
		if (cfg_r == auto_channel_config)
		begin
			set_ok = (card == 3'h0) || (card == CARD_ALL);
			qry_ok = (card == 3'h0);
			qc = 2'h0;
			sel = '1;
		end
		else
		begin
			set_ok = ((card >= 3'h1) && (card <= 3'(NCARD))) || (card == CARD_ALL);
			qry_ok = (card >= 3'h1) && (card <= 3'(NCARD));
			qc = 2'(card - 3'h1);
			sel = (card == CARD_ALL) ? '1 : NCARD'(4'h1 << qc);
		end
		mi.in_num = arg[3:0];
		mi.out_num = arg[7:4];
		mi.cp_mask = cp_r[qc];
		mi.cp_on = cpen_r[qc];
		case (op)
			op_seq_set: bad = !set_ok || (arg[1:0] == 2'b11);
			op_rule_set, op_open_card, op_card_pon: bad = !set_ok;
			op_coup_port_set: bad = !set_ok || |(sel & card_is_mux) || |(sel & cpl_hit);
			op_coup_en_set: bad = !set_ok || |(sel & card_is_mux);
			op_coup_port_qry, op_coup_en_qry: bad = !qry_ok || card_is_mux[qc];
			op_seq_qry: bad = !qry_ok;
			op_bias_set: bad = !set_ok || (arg[7:4] == 4'h0) || (arg[7:4] > 4'(NIN))
				|| |(sel & bias_hit);
			op_open_chan, op_close_chan: bad = !qry_ok || !mi.valid
				|| (bias_r[qc] && (mi.in0 == bp_r[qc] - 4'h1));
			op_func_set: bad = 1'b0;
			op_func_qry, op_dev_reset: bad = 1'b0;
			default: bad = 1'b1;
		endcase
		exec = (state_r == st_exec) && !bad;
		pon_all = exec && ((op == op_dev_reset)
			|| ((op == op_func_set) && (arg[0] != cfg_r)));
		case (op)
			op_seq_qry: qval = {6'h00, seq_r[qc]};
			op_coup_port_qry: qval = {3'h0, cp_r[qc]};
			op_coup_en_qry: qval = {7'h00, cpen_r[qc]};
			op_func_qry: qval = {7'h00, cfg_r};
			default: qval = 8'h00;
		endcase
		sq.mode = rule_r[qc] ? seq_r[qc] : no_sequence_mode;
		sq.start = exec && (op == op_close_chan);
		busy = (state_r != st_idle);
		apb_acc = psel && penable && !pready;
		cmd_go = apb_acc && pwrite && (paddr == A_CMD) && !busy;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (pce)
		begin
			pready <= apb_acc;
			if (apb_acc)
			begin
				// writes go to the command word only, and never while busy
				pslverr <= pwrite ? ((paddr != A_CMD) || busy)
					: !((paddr == A_CMD) || (paddr == A_STAT) || (paddr == A_RESP));
				case (paddr)
					A_CMD: prdata <= {16'h0000, cmd_r};
					A_STAT: prdata <= {29'h0, cfg_r, err_r, busy};
					A_RESP: prdata <= {15'h0000, resp_r};
					default: prdata <= 32'h0000_0000;
				endcase
			end
			else
			begin
				pslverr <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= st_idle;
			cmd_r <= 16'h0000;
			err_r <= 1'b0;
			resp_r <= 17'h00000;
		end
		else if (pce)
		begin
			case (state_r)
				st_idle:
				begin
					if (cmd_go)
					begin
						cmd_r <= pwdata[15:0];
						err_r <= 1'b0;
						resp_r <= 17'h00000;
						state_r <= st_exec;
					end
				end
				st_exec:
				begin
					err_r <= bad;
					if (!bad && ((op == op_seq_qry) || (op == op_coup_port_qry)
						|| (op == op_coup_en_qry) || (op == op_func_qry)))
						resp_r <= {1'b1, NEWLINE, qval};
					state_r <= sq.start ? st_seq : st_idle;
				end
				st_seq:
				begin
					if (sq.done)
						state_r <= st_idle;
				end
				default: state_r <= st_idle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_r <= normal_channel_config;
		else if (pce && exec && (op == op_dev_reset))
			cfg_r <= normal_channel_config;
		else if (pce && exec && (op == op_func_set))
			cfg_r <= rmr_cfg_type'(arg[0]);
	end

	genvar c;
	generate
		for (c = 0; c < NCARD; c++)
		begin : g_card
			logic [NREL-1:0] m;
			logic pon;
			logic hit;
			logic other;
			assign relay_state[c] = relay_r[c];
			// odd bias port numbers kept apart from coupled pairs
			assign cpl_hit[c] = bp_r[c][0] && arg[bp_r[c][3:1]];
			assign bias_hit[c] = arg[4] && cp_r[c][arg[7:5]] && (arg[7:4] <= 4'h9);
			assign pon = pon_all || (exec && sel[c] && (op == op_card_pon));

			always_comb
			begin
				m = relay_r[c];
				hit = sel[c] && (card != CARD_ALL);
				other = 1'b0;
				if (pon || (exec && sel[c] && (op == op_open_card)))
					m = '0;
				if (exec && hit && (op == op_open_chan))
				begin
					m[mi.idx0] = 1'b0;
					if (mi.pair)
						m[mi.idx1] = 1'b0;
				end
				if (hit && sq.open_p && rule_r[c])
				begin
					for (int i = 0; i < NIN; i++)
					begin
						if (4'(i) != mi.in0)
							m[i * NOUT + int'(mi.oc0)] = 1'b0;
						if (mi.pair && (4'(i) != mi.in0 + 4'h1))
							m[i * NOUT + int'(mi.oc0) + 1] = 1'b0;
					end
				end
				// both paths of a pair close together
				if (hit && sq.close_p)
				begin
					m[mi.idx0] = 1'b1;
					if (mi.pair)
						m[mi.idx1] = 1'b1;
				end
				// freed outputs fall back to bias
				if (bias_r[c] && !pon && !sq.busy)
				begin
					for (int j = 0; j < NOUT; j++)
					begin
						other = 1'b0;
						for (int i = 0; i < NIN; i++)
							if (4'(i) != bp_r[c] - 4'h1)
								other = other | m[i * NOUT + j];
						// bias on every free enabled output
						m[int'(bp_r[c] - 4'h1) * NOUT + j] = ben_r[c][j] && !other;
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					seq_r[c] <= break_first_default;
					rule_r[c] <= 1'b0;
					cp_r[c] <= RST_COUP;
					cpen_r[c] <= 1'b0;
					bias_r[c] <= 1'b0;
					bp_r[c] <= RST_BIAS_PORT;
					ben_r[c] <= RST_BIAS_EN;
					relay_r[c] <= '0;
				end
				else if (pce)
				begin
					relay_r[c] <= m;
					if (pon)
					begin
						seq_r[c] <= break_first_default;
						rule_r[c] <= 1'b0;
						cp_r[c] <= RST_COUP;
						cpen_r[c] <= 1'b0;
						bias_r[c] <= 1'b0;
						bp_r[c] <= RST_BIAS_PORT;
						ben_r[c] <= RST_BIAS_EN;
					end
					else if (exec && sel[c])
					begin
						case (op)
							op_seq_set: seq_r[c] <= rmr_seq_type'(arg[1:0]);
							op_rule_set: rule_r[c] <= arg[0];
							op_coup_port_set: cp_r[c] <= arg[4:0];
							op_coup_en_set: cpen_r[c] <= arg[0];
							op_bias_set:
							begin
								bias_r[c] <= arg[0];
								bp_r[c] <= arg[7:4];
							end
							default: ;
						endcase
					end
				end
			end
		end
	endgenerate

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_reset_seq_break: assert property (pce && exec && op == op_dev_reset |=>
		seq_r[0] == break_first_mode && seq_r[3] == break_first_mode)
		else $error("device reset left sequence mode");
	a_reset_no_couple: assert property (pce && exec && op == op_dev_reset |=>
		cp_r[1] == 5'h00 && !cpen_r[1])
		else $error("device reset left couple ports");
	a_reset_cfg_normal: assert property (pce && exec && op == op_dev_reset |=>
		cfg_r == normal_channel_config)
		else $error("device reset left auto config");
	a_func_opens_all: assert property (pce && pon_all |=>
		relay_r[0] == '0 && relay_r[2] == '0 && !bias_r[2])
		else $error("config change left relays closed");
	a_open_card_clear: assert property (pce && exec && sel[1] && op == op_open_card
		&& !bias_r[1] |=> relay_r[1] == '0)
		else $error("open card left relays closed");
	a_bad_cmd_kept: assert property (pce && state_r == st_exec && bad |=>
		err_r && $stable(seq_r[0]) && $stable(relay_r[0]) && state_r == st_idle)
		else $error("rejected command changed state");
	a_query_newline: assert property (pce && exec && op == op_seq_qry |=>
		resp_r[15:8] == NEWLINE && resp_r[F_RVALID] && resp_r[7:0] < 8'h03)
		else $error("sequence reply malformed");
	a_coup_en_store: assert property (pce && exec && sel[0] && op == op_coup_en_set
		|=> cpen_r[0] == $past(arg[0]))
		else $error("couple enable not stored");
	a_pair_odd_out: assert property (mi.pair && mi.valid |->
		!mi.oc0[0] && mi.idx1 == mi.idx0 + 7'd13)
		else $error("coupled output not odd");
	c_close_seq: cover property (pce && sq.start && sq.mode == break_first_mode);
	c_func_change: cover property (pon_all && op == op_func_set);
	c_bias_open: cover property (exec && op == op_open_card && bias_r[qc]);
endmodule

// ---- rmr_host.sv ----
// host model: apb master that issues route commands and polls status
// assumes a slave that answers every access with pready
`timescale 1ns/10ps
module rmr_host
	import rmr_pkg::*;
(
	// clock
	input wire logic pclk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// request held until pready is sampled high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed; the bench watchdog ends a hang
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// callers form only legal port fields, save refusal cases
	task automatic cmd(input logic [3:0] op, input logic [2:0] card, input logic [7:0] arg,
		output logic [31:0] resp, output logic err);
		logic [31:0] q;
		logic e;
		xfer(1'b1, A_CMD, {16'h0000, arg, 1'b0, card, op}, q, e);
		// busy polled so no write is refused mid-command
		do
		begin
			xfer(1'b0, A_STAT, 32'h0, q, e);
		end
		while (q[F_BUSY] !== 1'b0);
		err = q[F_ERR];
		xfer(1'b0, A_RESP, 32'h0, resp, e);
	endtask
endmodule

// ---- tb_relay_matrix_route_config.sv ----
// testbench for the relay route block, driven through the host model
// assumes relay bit (in-1)*12+(out-1), card n at index n-1
`timescale 1ns/10ps
module tb_relay_matrix_route_config
	import rmr_pkg::*;
;
	logic pclk;
	logic presetn;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rsp;
	logic [NCARD-1:0] card_is_mux;
	logic [NCARD-1:0][NREL-1:0] relay;
	logic er;
	int err_total = 0;
	int check_count = 0;

	rmr_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	rmr_route_cfg i_dut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .card_is_mux(card_is_mux), .relay_state(relay));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic chk(input logic [NCARD*NREL-1:0] got, input logic [NCARD*NREL-1:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("mismatches %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic run(input logic [3:0] op, input logic [2:0] card, input logic [7:0] arg);
		i_host.cmd(op, card, arg, rsp, er);
	endtask

	task automatic t_reset;
		i_host.xfer(1'b0, A_STAT, 32'h0, rsp, er);
		chk(rsp[F_AUTO], normal_channel_config);
		for (int c = 1; c <= NCARD; c++)
		begin
			run(op_seq_qry, 3'(c), 8'h00);
			chk(rsp, {15'h0, 1'b1, NEWLINE, 6'h0, break_first_default});
			run(op_coup_port_qry, 3'(c), 8'h00);
			chk(rsp[7:0], RST_COUP);
			run(op_coup_en_qry, 3'(c), 8'h00);
			chk(rsp[7:0], 8'h00);
		end
		chk(relay, '0);
	endtask

	task automatic t_seq;
		for (int m = 0; m < 3; m++)
		begin
			run(op_seq_set, 3'h2, 8'(m));
			run(op_seq_qry, 3'h2, 8'h00);
			chk(rsp[7:0], m);
		end
		run(op_seq_set, 3'h2, 8'h03);
		chk(er, 1'b1);
		run(op_seq_qry, 3'h2, 8'h00);
		chk(rsp[7:0], make_first_mode);
		run(op_seq_qry, CARD_ALL, 8'h00);
		chk(er, 1'b1);
	endtask

	task automatic t_couple;
		run(op_coup_port_set, 3'h1, 8'h05);
		run(op_coup_port_set, 3'h1, 8'h01);
		run(op_coup_port_qry, 3'h1, 8'h00);
		chk(rsp[7:0], 8'h01);
		run(op_coup_port_qry, 3'h3, 8'h00);
		chk(rsp[7:0], 8'h00);
		run(op_coup_en_set, 3'h1, 8'h01);
		run(op_coup_en_qry, 3'h1, 8'h00);
		chk(rsp[7:0], 8'h01);
		// even output 4 folds onto 3 and 4 for inputs 1 and 2
		run(op_close_chan, 3'h1, 8'h41);
		chk(relay[0], (120'h1 << 2) | (120'h1 << 15));
		run(op_open_card, 3'h1, 8'h00);
		run(op_coup_en_set, 3'h1, 8'h00);
		run(op_coup_en_qry, 3'h1, 8'h00);
		chk(rsp[7:0], 8'h00);
		card_is_mux <= 4'h8;
		run(op_coup_port_set, 3'h4, 8'h01);
		chk(er, 1'b1);
		run(op_coup_en_set, 3'h4, 8'h01);
		chk(er, 1'b1);
		card_is_mux <= 4'h0;
		run(op_bias_set, 3'h2, 8'h50);
		run(op_coup_port_set, 3'h2, 8'h04);
		chk(er, 1'b1);
		run(op_bias_set, 3'h1, 8'h11);
		chk(er, 1'b1);
	endtask

	task automatic t_bias;
		logic [NREL-1:0] e;
		run(op_close_chan, 3'h3, 8'h53);
		run(op_bias_set, 3'h3, 8'hA1);
		e = '0;
		e[28] = 1'b1;
		for (int o = 0; o < NOUT; o++)
			e[108 + o] = (o != 4);
		chk(relay[2], e);
		run(op_open_chan, 3'h3, 8'h53);
		e[28] = 1'b0;
		e[112] = 1'b1;
		chk(relay[2], e);
		run(op_close_chan, 3'h3, 8'h5A);
		chk(er, 1'b1);
		run(op_open_card, 3'h3, 8'h00);
		chk(relay[2], e);
		run(op_bias_set, 3'h3, 8'hA0);
		run(op_open_card, 3'h3, 8'h00);
		chk(relay[2], '0);
	endtask

	task automatic t_route;
		logic stop, both, none;
		run(op_rule_set, 3'h2, 8'h01);
		for (int m = 0; m < 3; m++)
		begin
			run(op_seq_set, 3'h2, 8'(m));
			run(op_open_card, 3'h2, 8'h00);
			run(op_close_chan, 3'h2, 8'h11);
			stop = 1'b0;
			both = 1'b0;
			none = 1'b0;
			// watch the old and new relay across the route change
			fork
				begin
					run(op_close_chan, 3'h2, 8'h12);
					stop = 1'b1;
				end
				while (!stop)
				begin
					@(posedge pclk);
					both |= relay[1][0] & relay[1][12];
					none |= !relay[1][0] & !relay[1][12];
				end
			join
			chk({both, none}, {m == 2, m == 1});
			chk({relay[1][12], relay[1][0]}, 2'b10);
		end
		run(op_rule_set, 3'h2, 8'h00);
		run(op_open_card, 3'h2, 8'h00);
		run(op_close_chan, 3'h2, 8'h11);
		run(op_close_chan, 3'h2, 8'h12);
		chk({relay[1][12], relay[1][0]}, 2'b11);
	endtask

	task automatic t_cfg;
		run(op_close_chan, 3'h1, 8'h11);
		run(op_func_set, CARD_ALL, 8'h01);
		chk(relay, '0);
		run(op_seq_qry, 3'h0, 8'h00);
		chk(rsp[7:0], break_first_default);
		run(op_func_qry, 3'h0, 8'h00);
		chk(rsp[7:0], auto_channel_config);
		run(op_seq_set, 3'h2, 8'h00);
		chk(er, 1'b1);
		run(op_dev_reset, 3'h0, 8'h00);
		run(op_func_qry, 3'h1, 8'h00);
		chk({er, rsp[7:0]}, {1'b0, 8'h00});
		// single card power-on reset
		run(op_seq_set, 3'h4, 8'h02);
		run(op_coup_en_set, 3'h4, 8'h01);
		run(op_close_chan, 3'h4, 8'h11);
		chk(relay[3][0], 1'b1);
		run(op_card_pon, 3'h4, 8'h00);
		chk(relay[3], '0);
		run(op_seq_qry, 3'h4, 8'h00);
		chk(rsp[7:0], break_first_default);
		run(op_coup_en_qry, 3'h4, 8'h00);
		chk(rsp[7:0], 8'h00);
		run(op_nop, 3'h1, 8'h00);
		chk(er, 1'b1);
	endtask

	task automatic t_bus;
		i_host.xfer(1'b0, 8'h0C, 32'h0, rsp, er);
		chk({er, rsp}, {1'b1, 32'h0});
		i_host.xfer(1'b1, A_STAT, 32'hFFFFFFFF, rsp, er);
		chk(er, 1'b1);
	endtask

	initial
	begin
		presetn = 1'b0;
		card_is_mux = 4'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_seq();
		t_couple();
		t_bias();
		t_route();
		t_cfg();
		t_bus();
		results();
	end

	// hang guard, far above the thousand or so cycles the scenarios need
	initial
	begin
		repeat (40000) @(posedge pclk);
		err_total++;
		results();
	end
endmodule
